/* File: logic/pgn_page_cap.sv */
// pgn_page_cap: holds the partner's latest next page and a latched arrival flag
// assumes: page_valid_in is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module pgn_page_cap
   import pgn_pkg::*;
(
   input  wire logic        clk_in,        // system clock
   input  wire logic        rst_in,        // async reset, high
   input  wire logic        page_valid_in, // complete page received
   input  wire logic [15:0] page_in,       // received page word
   input  wire logic        flag_clr_in,   // status read clears flag
   output logic      [15:0] page_out,      // held page
   output logic             rcvd_out       // latched arrival flag
);
   // all fields load together and hold until the next page
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         page_out <= PGN_NP_RST;
      else if (page_valid_in)
         page_out <= page_in;
   end
   // latched high; a new page beats the read clear
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         rcvd_out <= 1'b0;
      else if (page_valid_in)
         rcvd_out <= 1'b1;
      else if (flag_clr_in)
         rcvd_out <= 1'b0;
   end
endmodule : pgn_page_cap
`default_nettype wire

/* File: logic/pgn_regs.sv */
// pgn_regs: partner next page and gigabit control registers for one port
// assumes: plain register port, one clock, page pulses from negotiation logic
// Operation
// - test field selects normal or four tests
// - codes 101 to 111 produce no test
// - valid test drives all four pairs
// - bit 12 enables manual master-slave
// - bit 11 forces master or slave
// - bit 10 preference when manual off
// - bit 9 advertises gigabit full duplex
// - bit 8 half duplex; 7:0 reserved
// - bit 15 reports partner next page
// - bit 14 reports partner acknowledge
// - message page, ack2, message field read-only
// - bit 11 reports partner toggle
// - page received flag latched until read
`timescale 1ns/1ps
`default_nettype none
module pgn_regs
   import pgn_pkg::*;
#(
   parameter int PAIRS = 4 // differential pairs driven in test
)(
   input  wire logic             clk_in,        // 20 MHz clock
   input  wire logic             rst_in,        // async reset, high
   input  wire logic [15:0]      addr_in,       // register address
   input  wire logic [15:0]      wdata_in,      // write data
   input  wire logic             wr_in,         // write strobe
   input  wire logic             rd_in,         // read strobe
   output logic      [15:0]      rdata_out,     // read data, cycle after rd
   input  wire logic             page_valid_in, // partner page complete
   input  wire logic [15:0]      page_in,       // partner page word
   output logic      [2:0]       test_mode_out, // active test mode
   output logic      [PAIRS-1:0] test_pair_out, // pairs carrying test waveform
   output logic      [1:0]       ms_cfg_out,    // master-slave request
   output logic                  adv_fd_out,    // advertise 1000 full duplex
   output logic                  adv_hd_out     // advertise 1000 half duplex
);
   logic [15:0] gig_ctrl_ff;  // gigabit control register
   logic [15:0] np_hold;      // held partner page
   logic        np_rcvd;      // latched page flag
   logic        flag_clr;     // status read clears flag
   logic [1:0]  nxt_ms_cfg;   // next master-slave request
   pgn_cfg_if   cfg ();       // control word to test selector

   // decode a register hit
   function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // control register, reserved low byte stays zero
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         gig_ctrl_ff <= PGN_GIG_RST;
      else if (wr_in && hit(addr_in, PGN_OFS_GIG_CTRL))
         gig_ctrl_ff <= wdata_in & PGN_GIG_WMASK;
   end

   assign flag_clr = rd_in && hit(addr_in, PGN_OFS_NP_STATUS);
   assign cfg.test_code = gig_ctrl_ff[PGN_TEST_HI:PGN_TEST_LO];

   // selector keeps reserved codes out of the transmitter
   pgn_test_sel u_sel (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .cfg    (cfg.dst)
   );

   // partner page capture and arrival flag
   pgn_page_cap u_cap (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .page_valid_in (page_valid_in),
      .page_in       (page_in),
      .flag_clr_in   (flag_clr),
      .page_out      (np_hold),
      .rcvd_out      (np_rcvd)
   );

   // read data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         rdata_out <= 16'h0000;
      else if (!rd_in)
         rdata_out <= 16'h0000;
      else if (hit(addr_in, PGN_OFS_PARTNER_NP))
         rdata_out <= np_hold;
      else if (hit(addr_in, PGN_OFS_GIG_CTRL))
         rdata_out <= gig_ctrl_ff;
      else if (hit(addr_in, PGN_OFS_NP_STATUS))
         rdata_out <= 16'(np_rcvd) << PGN_PG_RCV_BIT;
      else
         rdata_out <= 16'h0000;
   end

   // manual setting wins; otherwise the port type preference is sent
   always_comb
   begin
      if (gig_ctrl_ff[PGN_MAN_EN])
         nxt_ms_cfg = gig_ctrl_ff[PGN_MAN_VAL] ? PGN_MS_FORCE_MASTER
                                               : PGN_MS_FORCE_SLAVE;
      else
         nxt_ms_cfg = gig_ctrl_ff[PGN_PORT_TYPE] ? PGN_MS_PREF_MASTER
                                                 : PGN_MS_PREF_SLAVE;
   end

   // registered outputs toward negotiation and transmitter
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ms_cfg_out    <= PGN_MS_PREF_MASTER;
         adv_fd_out    <= 1'b1;
         adv_hd_out    <= 1'b1;
         test_mode_out <= 3'h0;
         test_pair_out <= '0;
      end
      else
      begin
         ms_cfg_out    <= nxt_ms_cfg;
         adv_fd_out    <= gig_ctrl_ff[PGN_ADV_FD];
         adv_hd_out    <= gig_ctrl_ff[PGN_ADV_HD];
         test_mode_out <= cfg.test_mode;
         test_pair_out <= cfg.test_on ? '1 : '0; // no link needed
      end
   end

   // checks
   // the control word must come out of reset with the documented defaults
   chk_rst_value: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(rst_in) |-> gig_ctrl_ff == PGN_GIG_RST) else $error("control reset wrong");
   // write edge, register, selector, output: three edges from strobe to pairs
   chk_test_pairs: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_in && hit(addr_in, PGN_OFS_GIG_CTRL)
       && wdata_in[PGN_TEST_HI:PGN_TEST_LO] inside {[PGN_TM_WAVEFORM:PGN_TM_DISTORT]})
      |-> ##3 (test_pair_out == '1)) else $error("test not on all pairs");
   chk_test_rsvd: assert property (@(posedge clk_in) disable iff (rst_in)
      (wr_in && hit(addr_in, PGN_OFS_GIG_CTRL)
       && wdata_in[PGN_TEST_HI:PGN_TEST_LO] > PGN_TM_DISTORT)
      |-> ##3 (test_pair_out == '0)) else $error("reserved code ran a test");
   chk_test_mode: assert property (@(posedge clk_in) disable iff (rst_in)
      test_pair_out == '1 |-> test_mode_out inside {[PGN_TM_WAVEFORM:PGN_TM_DISTORT]})
      else $error("bad test mode");
   chk_manual_ms: assert property (@(posedge clk_in) disable iff (rst_in)
      gig_ctrl_ff[PGN_MAN_EN] |=> ms_cfg_out == {1'b1, $past(gig_ctrl_ff[PGN_MAN_VAL])})
      else $error("manual master-slave wrong");
   chk_pref_ms: assert property (@(posedge clk_in) disable iff (rst_in)
      !gig_ctrl_ff[PGN_MAN_EN] |=> ms_cfg_out == {1'b0, $past(gig_ctrl_ff[PGN_PORT_TYPE])})
      else $error("preference wrong");
   chk_adv_bits: assert property (@(posedge clk_in) disable iff (rst_in)
      (adv_fd_out == $past(gig_ctrl_ff[PGN_ADV_FD]))
      && (adv_hd_out == $past(gig_ctrl_ff[PGN_ADV_HD])))
      else $error("advertisement wrong");
   chk_rsvd_low: assert property (@(posedge clk_in) disable iff (rst_in)
      gig_ctrl_ff[7:0] == 8'h00) else $error("reserved bits set");
   // every page pulse must replace the whole held word in the next cycle
   chk_page_load: assert property (@(posedge clk_in) disable iff (rst_in)
      page_valid_in |=> np_hold == $past(page_in)) else $error("page not loaded");
   // held page must not drift between pulses
   chk_page_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      !page_valid_in |=> np_hold == $past(np_hold)) else $error("page drifted");
   // a read of the control word returns the register as it stood at the strobe
   chk_rd_ctrl: assert property (@(posedge clk_in) disable iff (rst_in)
      (rd_in && hit(addr_in, PGN_OFS_GIG_CTRL)) |=> rdata_out == $past(gig_ctrl_ff))
      else $error("control read wrong");
   // a status read with no new page must clear the latched flag
   chk_flag_clr: assert property (@(posedge clk_in) disable iff (rst_in)
      (flag_clr && !page_valid_in) |=> !np_rcvd) else $error("page flag not cleared");
   chk_flag_set: assert property (@(posedge clk_in) disable iff (rst_in)
      page_valid_in |=> np_rcvd) else $error("page flag not set");
   chk_flag_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      (np_rcvd && !flag_clr) |=> np_rcvd) else $error("page flag dropped");
   chk_rd_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      !rd_in |=> rdata_out == 16'h0000) else $error("read data lingers");
   cov_test_on:  cover property (@(posedge clk_in) test_pair_out == '1);
   cov_manual:   cover property (@(posedge clk_in) ms_cfg_out == PGN_MS_FORCE_MASTER);
   cov_page_rd:  cover property (@(posedge clk_in) np_rcvd && flag_clr);
endmodule : pgn_regs
`default_nettype wire

/* File: logic/pgn_test_sel.sv */
// pgn_test_sel: turns the test field into a registered test selection
// assumes: the field comes from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module pgn_test_sel
   import pgn_pkg::*;
(
   input  wire logic clk_in, // system clock
   input  wire logic rst_in, // async reset, high
   pgn_cfg_if.dst    cfg     // control word
);
   // reserved codes leave the transmitter in normal operation
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cfg.test_on   <= 1'b0;
         cfg.test_mode <= 3'h0;
      end
      else
      begin
         case (cfg.test_code)
            PGN_TM_WAVEFORM, PGN_TM_JIT_MST, PGN_TM_JIT_SLV, PGN_TM_DISTORT:
            begin
               cfg.test_on   <= 1'b1;
               cfg.test_mode <= cfg.test_code;
            end
            default:
            begin
               cfg.test_on   <= 1'b0;
               cfg.test_mode <= 3'h0;
            end
         endcase
      end
   end
endmodule : pgn_test_sel
`default_nettype wire

/* File: pkg/pgn_cfg_if.sv */
// pgn_cfg_if: raw test field carried from the register file to the test selector, decoded selection carried back
// assumes: driven and read on the same clock
`timescale 1ns/1ps
`default_nettype none
interface pgn_cfg_if;
   logic [2:0] test_code; // raw test field
   logic       test_on;   // valid test mode selected
   logic [2:0] test_mode; // latched valid mode
   modport src (output test_code, input test_on, input test_mode);
   modport dst (input test_code, output test_on, output test_mode);
endinterface : pgn_cfg_if
`default_nettype wire

/* File: pkg/pgn_pkg.sv */
// pgn_pkg: shared constants and types for the gigabit next page / control slice
// assumes: a single 20 MHz clock domain and a plain register port
package pgn_pkg;
   // register offsets (byte addresses of the 16-bit registers)
   localparam logic [15:0] PGN_OFS_PARTNER_NP = 16'h0110; // partner next page
   localparam logic [15:0] PGN_OFS_GIG_CTRL   = 16'h0112; // gigabit control
   localparam logic [15:0] PGN_OFS_NP_STATUS  = 16'h0114; // page received status (own)
   // gigabit control field positions
   localparam int PGN_TEST_HI   = 15;
   localparam int PGN_TEST_LO   = 13;
   localparam int PGN_MAN_EN    = 12;
   localparam int PGN_MAN_VAL   = 11;
   localparam int PGN_PORT_TYPE = 10;
   localparam int PGN_ADV_FD    = 9;
   localparam int PGN_ADV_HD    = 8;
   // writable mask and reset value of gigabit control, reset value of the held partner page
   localparam logic [15:0] PGN_GIG_WMASK = 16'hFF00;
   localparam logic [15:0] PGN_GIG_RST   = 16'h0700;
   localparam logic [15:0] PGN_NP_RST    = 16'h0000;
   // received page status bit
   localparam int PGN_PG_RCV_BIT = 1;
   // test mode codes
   typedef enum logic [2:0] {
      PGN_TM_NORMAL   = 3'h0,
      PGN_TM_WAVEFORM = 3'h1,
      PGN_TM_JIT_MST  = 3'h2,
      PGN_TM_JIT_SLV  = 3'h3,
      PGN_TM_DISTORT  = 3'h4
   } pgn_test_t;
   // master/slave resolution request to negotiation
   typedef enum logic [1:0] {
      PGN_MS_PREF_SLAVE  = 2'h0,
      PGN_MS_PREF_MASTER = 2'h1,
      PGN_MS_FORCE_SLAVE = 2'h2,
      PGN_MS_FORCE_MASTER = 2'h3
   } pgn_ms_t;
endpackage : pgn_pkg

/* File: tb/pgn_partner.sv */
// pgn_partner: link partner model that delivers one next page per request
// assumes: the same system clock as the block, lag of 0 to 3 cycles
`timescale 1ns/1ps
`default_nettype none
module pgn_partner
(
   input  wire logic        clk_in,         // system clock
   input  wire logic        rst_in,         // async reset, high
   input  wire logic        go_in,          // send a page
   input  wire logic [1:0]  lag_in,         // extra cycles before the page
   input  wire logic [15:0] word_in,        // page to send
   output logic             page_valid_out, // complete page pulse
   output logic      [15:0] page_out        // page word
);
   logic [2:0]  cnt_ff;  // cycles left until the page goes out
   logic [15:0] word_ff; // page waiting to go out
   // whole word with its pulse; between pages the word lines flip so stale data never passes
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_ff         <= 3'h0;
         word_ff        <= 16'h0000;
         page_valid_out <= 1'b0;
         page_out       <= 16'h0000;
      end
      else
      begin
         page_valid_out <= (cnt_ff == 3'h1);
         page_out       <= (cnt_ff == 3'h1) ? word_ff : ~page_out;
         if (go_in)
         begin
            cnt_ff  <= {1'b0, lag_in} + 3'h1;
            word_ff <= word_in;
         end
         else if (cnt_ff != 3'h0)
            cnt_ff <= cnt_ff - 3'h1;
      end
   end
endmodule : pgn_partner
`default_nettype wire

/* File: tb/tb.sv */
// tb: self-checking bench for the next page and gigabit control registers
// assumes: pgn_regs with four pairs, partner model on the page inputs
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pgn_pkg::*;
   logic clk_in = 1'b0;            // 20 MHz clock
   logic rst_in = 1'b1;            // async reset
   logic [15:0] addr_in = 16'h0000, wdata_in = 16'h0000, rdata_out;
   logic wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0;
   logic go = 1'b0;                // partner request
   logic [1:0] lag = 2'h0;         // partner lag
   logic [15:0] word = 16'h0000;   // page handed to partner
   logic pv;
   logic [15:0] pw;
   logic [2:0] test_mode_out;
   logic [3:0] test_pair_out;
   logic [1:0] ms_cfg_out;
   logic adv_fd_out, adv_hd_out;
   logic [15:0] seed = 16'h005D;   // xorshift state
   logic [15:0] q[$];              // expected read data, oldest first
   int miscompares = 0, check_count = 0, cyc = 0;
   logic [15:0] r, e;
   always #25 clk_in = ~clk_in;
   pgn_partner u_pgn_partner (.clk_in(clk_in), .rst_in(rst_in), .go_in(go), .lag_in(lag),
      .word_in(word), .page_valid_out(pv), .page_out(pw));
   pgn_regs #(.PAIRS(4)) u_pgn_regs (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .page_valid_in(pv), .page_in(pw), .test_mode_out(test_mode_out),
      .test_pair_out(test_pair_out), .ms_cfg_out(ms_cfg_out),
      .adv_fd_out(adv_fd_out), .adv_hd_out(adv_hd_out));
   function automatic logic [15:0] xs();
      seed = seed ^ (seed << 7);
      seed = seed ^ (seed >> 9);
      seed = seed ^ (seed << 8);
      return seed;
   endfunction : xs
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask : wr
   // a read notes its expectation; the monitor below takes it off
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      q.push_back(exp);
      @(posedge clk_in);
      rd_in   <= 1'b0;
   endtask : rd
   task automatic send_page(input logic [15:0] w, input logic [1:0] l);
      @(posedge clk_in);
      word <= w;
      lag  <= l;
      go   <= 1'b1;
      @(posedge clk_in);
      go   <= 1'b0;
      repeat (6) @(posedge clk_in);
   endtask : send_page
   // read data stand only in the cycle after the strobe
   always @(posedge clk_in)
   begin
      if (rd_d)
         check("rdata", rdata_out, q.pop_front());
      rd_d <= rd_in;
   end
   // hang guard, far above the hundred or so cycles the run needs
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(PGN_OFS_GIG_CTRL, 16'h0700);
      rd(PGN_OFS_PARTNER_NP, 16'h0000);
      rd(PGN_OFS_NP_STATUS, 16'h0000);
      @(negedge clk_in);
      check("ms", {14'h0000, ms_cfg_out}, 16'h0001);
      // base control write lands outside this slice and reads back as zero
      wr(16'h0100, 16'h0140);
      rd(16'h0100, 16'h0000);
      for (int c = 0; c < 8; c++)
      begin
         r = xs();
         e = {c[2:0], r[12:8], 8'h00};
         wr(PGN_OFS_GIG_CTRL, {c[2:0], r[12:0]});
         rd(PGN_OFS_GIG_CTRL, e);
         repeat (2) @(posedge clk_in);
         @(negedge clk_in);
         check("mode", {13'h0000, test_mode_out}, (c < 5) ? e[15:13] : 3'h0);
         check("pairs", {12'h000, test_pair_out}, (c > 0 && c < 5) ? 4'hF : 4'h0);
         check("ms", {14'h0000, ms_cfg_out}, {e[12], e[12] ? e[11] : e[10]});
         check("adv", {14'h0000, adv_fd_out, adv_hd_out}, {14'h0000, e[9:8]});
      end
      // two pages, prompt then slow; the second replaces the first whole
      for (int p = 0; p < 2; p++)
      begin
         r = xs();
         send_page(r, p[0] ? 2'h3 : 2'h0);
         wr(PGN_OFS_PARTNER_NP, ~r);
         rd(PGN_OFS_PARTNER_NP, r);
         rd(PGN_OFS_NP_STATUS, 16'h0002);
         rd(PGN_OFS_NP_STATUS, 16'h0000);
      end
      repeat (3) @(posedge clk_in);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
